// >>> pkg/ebo_pkg.sv
// constants and types for the external bus ownership control block
package ebo_pkg;

    // number of peer request lines and strap width
    localparam int EBO_NUM_PEERS = 6;
    localparam int EBO_ID_W = 3;

    // strap code of a single-processor system
    localparam logic [2:0] EBO_ID_SINGLE = 3'h0;

    // values after reset
    localparam logic EBO_RST_DRIVE_OFF_N = 1'h1;
    localparam logic EBO_RST_GRANT_N = 1'h1;
    localparam logic [2:0] EBO_RST_ID = 3'h0;

    // ownership states
    typedef enum logic [2:0] {
        EBO_IDLE,
        EBO_REQ,
        EBO_MASTER,
        EBO_HOST_REL,
        EBO_HOST_GRANT
    } ebo_state_type;

    // peer request pins, one output and one enable per line
    typedef struct packed {
        logic [EBO_NUM_PEERS-1:0] out_n;
        logic [EBO_NUM_PEERS-1:0] oe_n;
    } ebo_peer_pins_type;

    // all state of the block
    typedef struct packed {
        ebo_state_type state;
        logic [EBO_ID_W-1:0] id;
        logic captured;
        logic bus_oe_n;
        logic grant_n;
        logic grant_oe_n;
    } ebo_regs_type;

endpackage : ebo_pkg

// >>> hw/ebo_bus_owner.sv
// external bus ownership control: host grant, suspend, ready and peer requests
`timescale 1ns/10ps

module ebo_bus_owner (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic suspend_bus_tristate_n_i,
    input wire logic host_bus_request_n_i,
    input wire logic host_chip_select_n_i,
    input wire logic host_access_wait_i,
    input wire logic ready_active_drive_sel_i,
    input wire logic [2:0] processor_identity_straps_i,
    input wire logic [5:0] peer_bus_request_n_i,
    input wire logic host_bus_grant_n_i,
    input wire logic core_bus_want_i,
    input wire logic core_access_i,
    output logic core_stall_o,
    output logic bus_master_o,
    output logic ext_bus_oe_n_o,
    output logic host_bus_grant_n_o,
    output logic host_bus_grant_oe_n_o,
    output logic host_access_ready_o,
    output logic host_access_ready_oe_n_o,
    output logic host_grant_seen_o,
    output ebo_pkg::ebo_peer_pins_type peer_bus_o
);

    ebo_pkg::ebo_regs_type regs_ff;
    ebo_pkg::ebo_regs_type nxt_regs;
    logic host_req;
    logic single_proc;
    logic [5:0] own_sel;
    logic [5:0] peer_req;
    logic [5:0] higher_mask;
    logic higher_req;

    // how the pieces fit together:
    // the straps are caught once, at the first edge after reset, and then frozen;
    // a captured code of 1 to 6 picks the one peer request line that this block may drive,
    // every other line is only watched, and lower line numbers win among peers;
    // a host request outranks every peer and pulls an owned bus away in two steps,
    // first the external bus floats, one cycle later the host grant goes low;
    // suspend floats the bus for the following cycle whatever the state is,
    // so a core access has to stall until suspend lifts and the bus is driven again

    // one-hot select of the own peer line from the captured straps
    genvar gi;
    generate
        for (gi = 0; gi < ebo_pkg::EBO_NUM_PEERS; gi++) begin : g_peer
            assign own_sel[gi] = regs_ff.captured && (regs_ff.id == 3'(gi + 1));
            assign higher_mask[gi] = (3'(gi + 1) < regs_ff.id);
            // drive only the own line, float the rest for monitoring
            assign peer_bus_o.oe_n[gi] = ~own_sel[gi];
            assign peer_bus_o.out_n[gi] = ~(own_sel[gi] && regs_ff.state == ebo_pkg::EBO_REQ
                                            || own_sel[gi] && regs_ff.state == ebo_pkg::EBO_MASTER);
            // clock named here, the default clocking below is declared later in the module
            a_own_line: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
                                         !peer_bus_o.oe_n[gi] |-> regs_ff.id == 3'(gi + 1))
                else $error("peer line driven that the straps do not select");
        end
    endgenerate

    // lines of lower number win among peers; unused ones idle high on the board
    assign host_req = ~host_bus_request_n_i;
    assign single_proc = (regs_ff.id == ebo_pkg::EBO_ID_SINGLE);
    assign peer_req = ~peer_bus_request_n_i & ~own_sel;
    assign higher_req = |(peer_req & higher_mask);

    // ownership state machine and registered pin state
    always_comb begin
        nxt_regs = regs_ff;
        // straps caught once after reset release, never while running
        if (!regs_ff.captured) begin
            nxt_regs.id = processor_identity_straps_i;
            nxt_regs.captured = 1'b1;
        end
        case (regs_ff.state)
            ebo_pkg::EBO_IDLE: begin
                if (regs_ff.captured && core_bus_want_i && !host_req) begin
                    if (single_proc) begin
                        nxt_regs.state = ebo_pkg::EBO_MASTER;
                    end else begin
                        nxt_regs.state = ebo_pkg::EBO_REQ;
                    end
                end
            end
            ebo_pkg::EBO_REQ: begin
                // a host request blocks the win even if no peer competes
                if (!core_bus_want_i) begin
                    nxt_regs.state = ebo_pkg::EBO_IDLE;
                end else if (!host_req && !higher_req) begin
                    nxt_regs.state = ebo_pkg::EBO_MASTER;
                end
            end
            ebo_pkg::EBO_MASTER: begin
                if (host_req) begin
                    nxt_regs.state = ebo_pkg::EBO_HOST_REL;
                end else if (!core_bus_want_i) begin
                    nxt_regs.state = ebo_pkg::EBO_IDLE;
                end
            end
            ebo_pkg::EBO_HOST_REL: begin
                // bus already floated for a cycle before the grant goes low
                if (host_req) begin
                    nxt_regs.state = ebo_pkg::EBO_HOST_GRANT;
                end else begin
                    nxt_regs.state = ebo_pkg::EBO_MASTER;
                end
            end
            ebo_pkg::EBO_HOST_GRANT: begin
                if (!host_req) begin
                    nxt_regs.state = core_bus_want_i ? ebo_pkg::EBO_MASTER
                                                     : ebo_pkg::EBO_IDLE;
                end
            end
            default: begin
                nxt_regs.state = ebo_pkg::EBO_IDLE;
            end
        endcase
        // bus drivers on only as master and never in the cycle after a suspended one
        nxt_regs.bus_oe_n = ~(nxt_regs.state == ebo_pkg::EBO_MASTER
                              && suspend_bus_tristate_n_i);
        nxt_regs.grant_n = ~(nxt_regs.state == ebo_pkg::EBO_HOST_GRANT);
        nxt_regs.grant_oe_n = ~(nxt_regs.state == ebo_pkg::EBO_MASTER
                                || nxt_regs.state == ebo_pkg::EBO_HOST_REL
                                || nxt_regs.state == ebo_pkg::EBO_HOST_GRANT);
    end

    // state register; constants only under reset
    // the straps are not read here on purpose: a reset branch that copies an input
    // would make the reset value depend on a pin, which the async path must avoid
    always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            regs_ff.state <= ebo_pkg::EBO_IDLE;
            regs_ff.id <= ebo_pkg::EBO_RST_ID;
            regs_ff.captured <= 1'b0;
            regs_ff.bus_oe_n <= ebo_pkg::EBO_RST_DRIVE_OFF_N;
            regs_ff.grant_n <= ebo_pkg::EBO_RST_GRANT_N;
            regs_ff.grant_oe_n <= ebo_pkg::EBO_RST_DRIVE_OFF_N;
        end else begin
            regs_ff <= nxt_regs;
        end
    end

    // core side: an access waits until suspend lifts and the bus is ours
    assign core_stall_o = core_access_i && (!suspend_bus_tristate_n_i || regs_ff.bus_oe_n);
    assign bus_master_o = (regs_ff.state == ebo_pkg::EBO_MASTER);
    assign ext_bus_oe_n_o = regs_ff.bus_oe_n;
    assign host_bus_grant_n_o = regs_ff.grant_n;
    assign host_bus_grant_oe_n_o = regs_ff.grant_oe_n;
    // a non-master only watches the shared grant line
    assign host_grant_seen_o = ~host_bus_grant_n_i;

    // ready: open drain only ever pulls low, active drive also drives high
    // the value itself is always present; only the enable decides whether the pin
    // sees it, so the open drain case relies on the board pull-up for the high level
    always_comb begin
        host_access_ready_o = ~host_access_wait_i;
        host_access_ready_oe_n_o = 1'b1;
        if (!host_chip_select_n_i && host_req) begin
            if (ready_active_drive_sel_i || host_access_wait_i) begin
                host_access_ready_oe_n_o = 1'b0;
            end
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (sys_rst_i);

    // checks of the ownership behaviour
    a_suspend_float: assert property (!suspend_bus_tristate_n_i |=> ext_bus_oe_n_o)
        else $error("bus still driven the cycle after suspend");
    a_suspend_stall: assert property (core_access_i && !suspend_bus_tristate_n_i
                                      |-> core_stall_o)
        else $error("external access not stalled under suspend");
    a_host_grant_seq: assert property (bus_master_o && host_req ##1 host_req
                                       |=> !host_bus_grant_n_o)
        else $error("host grant not given two cycles after request");
    a_grant_floated: assert property (!host_bus_grant_n_o |-> ext_bus_oe_n_o)
        else $error("bus driven while host holds grant");
    a_host_priority: assert property (regs_ff.state == ebo_pkg::EBO_REQ && host_req
                                      |=> !bus_master_o)
        else $error("peer win taken over a host request");
    a_grant_hold: assert property (!host_bus_grant_n_o && host_req |=> !host_bus_grant_n_o)
        else $error("grant dropped while host still requests");
    a_grant_release: assert property (!host_bus_grant_n_o && !host_req |=> host_bus_grant_n_o)
        else $error("grant not released after request withdrawn");
    a_grant_driver: assert property (!host_bus_grant_oe_n_o |-> regs_ff.state != ebo_pkg::EBO_IDLE
                                     && regs_ff.state != ebo_pkg::EBO_REQ)
        else $error("grant driven by a non-master");
    a_ready_gate: assert property (!host_access_ready_oe_n_o
                                   |-> !host_chip_select_n_i && host_req)
        else $error("ready driven without select and request");
    a_ready_od: assert property (!host_access_ready_oe_n_o && !ready_active_drive_sel_i
                                 |-> !host_access_ready_o)
        else $error("open drain ready driven high");
    a_ready_wait: assert property (!host_chip_select_n_i && host_req && host_access_wait_i
                                   |-> !host_access_ready_oe_n_o && !host_access_ready_o)
        else $error("wait state not signalled on ready");
    a_strap_freeze: assert property (regs_ff.captured |=> $stable(regs_ff.id))
        else $error("identity changed after capture");

    // an idle block never drives the external bus
    a_idle_floated: assert property (regs_ff.state == ebo_pkg::EBO_IDLE
                                     |-> ext_bus_oe_n_o)
        else $error("bus driven while idle");

    // the grant is only ever low in the host grant state
    a_grant_state: assert property (!host_bus_grant_n_o
                                    |-> regs_ff.state == ebo_pkg::EBO_HOST_GRANT)
        else $error("grant low outside the host grant state");

    // in the release step the bus is already floated but the grant not yet given
    a_release_step: assert property (regs_ff.state == ebo_pkg::EBO_HOST_REL
                                     |-> ext_bus_oe_n_o && host_bus_grant_n_o)
        else $error("release step drives the bus or grants early");

    // a withdrawn request during the release step hands the bus back to the core
    a_release_back: assert property (regs_ff.state == ebo_pkg::EBO_HOST_REL && !host_req
                                     |=> bus_master_o)
        else $error("bus not taken back after request withdrawn");

    // a single-processor code selects no peer line at all
    a_single_no_line: assert property (regs_ff.captured && single_proc
                                       |-> &peer_bus_o.oe_n)
        else $error("peer line driven in a single-processor system");

    // at most one peer line is ever driven by this block
    a_one_line: assert property ($onehot0(~peer_bus_o.oe_n))
        else $error("more than one peer line driven");

    // an idle block does not request the bus from its peers
    a_idle_no_req: assert property (regs_ff.state == ebo_pkg::EBO_IDLE
                                    |-> &peer_bus_o.out_n)
        else $error("peer request asserted while idle");

    // a pending higher peer keeps this block waiting
    a_peer_blocks: assert property (regs_ff.state == ebo_pkg::EBO_REQ && higher_req
                                    |=> !bus_master_o)
        else $error("bus taken over a higher peer request");

    // a floated bus always stalls a core access
    a_stall_floated: assert property (core_access_i && ext_bus_oe_n_o
                                      |-> core_stall_o)
        else $error("access not stalled on a floated bus");

    // a driven bus with suspend lifted lets the access through
    a_no_stall: assert property (core_access_i && !ext_bus_oe_n_o && suspend_bus_tristate_n_i
                                 |-> !core_stall_o)
        else $error("access stalled on a driven bus");

    // the ready level follows the wait request at all times
    a_ready_level: assert property (host_access_ready_o == !host_access_wait_i)
        else $error("ready level does not follow wait");

    // active drive mode drives the pin whenever select and request are low
    a_ready_active: assert property (!host_chip_select_n_i && host_req
                                     && ready_active_drive_sel_i
                                     |-> !host_access_ready_oe_n_o)
        else $error("ready not driven in active drive mode");

    // the bus master always owns the grant wire
    a_master_grant_oe: assert property (bus_master_o |-> !host_bus_grant_oe_n_o)
        else $error("master does not drive the grant wire");

    // a watching device follows the shared grant wire
    a_grant_watch: assert property (host_grant_seen_o == !host_bus_grant_n_i)
        else $error("shared grant not followed");

    c_host_grant: cover property (bus_master_o ##1 host_req [*3] ##1 !host_bus_grant_n_o);
    c_suspend_stall: cover property (core_stall_o && !suspend_bus_tristate_n_i);
    c_peer_win: cover property (regs_ff.state == ebo_pkg::EBO_REQ ##1 bus_master_o);
    c_ready_wait: cover property (!host_access_ready_oe_n_o && !host_access_ready_o);
    // the host gives up in the release step and the core keeps its bus
    c_release_back: cover property (regs_ff.state == ebo_pkg::EBO_HOST_REL ##1 bus_master_o);

endmodule : ebo_bus_owner

// >>> testbench/ebo_far_side.sv
// far side model: host requester, peer requesters, board pull-ups, shared grant wire
`timescale 1ns/10ps
module ebo_far_side (
    input wire logic host_req_i,
    input wire logic host_cs_i,
    input wire logic [5:0] peer_req_i,
    input wire ebo_pkg::ebo_peer_pins_type peer_bus_i,
    input wire logic grant_n_i,
    input wire logic grant_oe_n_i,
    output logic host_bus_request_n_o,
    output logic host_chip_select_n_o,
    output logic [5:0] peer_bus_request_n_o,
    output logic host_bus_grant_n_o
);
    // host pins are active low copies of the bench commands
    assign host_bus_request_n_o = ~host_req_i;
    assign host_chip_select_n_o = ~host_cs_i;
    // own line from the device, others from peers, idle lines pulled high
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            if (!peer_bus_i.oe_n[i])
                peer_bus_request_n_o[i] = peer_bus_i.out_n[i];
            else
                peer_bus_request_n_o[i] = ~peer_req_i[i];
        end
    end
    // grant wire floats to its pull-up when nobody drives it
    assign host_bus_grant_n_o = grant_oe_n_i ? 1'h1 : grant_n_i;
endmodule : ebo_far_side

// >>> testbench/test_ebo_bus_owner.sv
// self-checking bench for the bus ownership block
`timescale 1ns/10ps
module test_ebo_bus_owner;
    logic clk = 1'h0, rst = 1'h1, sus_n = 1'h1, wait_r = 1'h0, sel = 1'h0;
    logic want = 1'h0, acc = 1'h0, hreq = 1'h0, hcs = 1'h0;
    logic [2:0] ids = 3'h0;
    logic [5:0] preq = 6'h00;
    logic [5:0] pbr_n;
    logic hbr_n, hcs_n, gnt_w, stall, mst, boe_n, gnt_n, goe_n, rdy, roe_n, seen;
    ebo_pkg::ebo_peer_pins_type pbus;
    int errors = 0;
    int n_tests = 0;
    always #20 clk = ~clk;
    ebo_bus_owner ebo_bus_owner_inst (.sys_clk_i(clk), .sys_rst_i(rst),
        .suspend_bus_tristate_n_i(sus_n), .host_bus_request_n_i(hbr_n),
        .host_chip_select_n_i(hcs_n), .host_access_wait_i(wait_r),
        .ready_active_drive_sel_i(sel), .processor_identity_straps_i(ids),
        .peer_bus_request_n_i(pbr_n), .host_bus_grant_n_i(gnt_w), .core_bus_want_i(want),
        .core_access_i(acc), .core_stall_o(stall), .bus_master_o(mst),
        .ext_bus_oe_n_o(boe_n), .host_bus_grant_n_o(gnt_n), .host_bus_grant_oe_n_o(goe_n),
        .host_access_ready_o(rdy), .host_access_ready_oe_n_o(roe_n),
        .host_grant_seen_o(seen), .peer_bus_o(pbus));
    ebo_far_side ebo_far_side_inst (.host_req_i(hreq), .host_cs_i(hcs), .peer_req_i(preq),
        .peer_bus_i(pbus), .grant_n_i(gnt_n), .grant_oe_n_i(goe_n),
        .host_bus_request_n_o(hbr_n), .host_chip_select_n_o(hcs_n),
        .peer_bus_request_n_o(pbr_n), .host_bus_grant_n_o(gnt_w));
    task automatic chk(input string nm, input logic [5:0] seen_v, input logic [5:0] exp_v);
        n_tests++;
        if (seen_v !== exp_v) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, exp_v, seen_v);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // straps move only while reset is held
    task automatic do_reset(input logic [2:0] id);
        rst = 1'h1;
        ids = id;
        cyc(20);
        rst = 1'h0;
        cyc(1);
    endtask : do_reset
    // every strap code: which line is driven, and the single-processor case
    task automatic t_straps;
        logic [5:0] exp;
        for (int i = 0; i < 8; i++) begin
            do_reset(3'(i));
            exp = (i >= 1 && i <= 6) ? ~(6'h01 << (i - 1)) : 6'h3F;
            chk("peer_oe", pbus.oe_n, exp);
            want = 1'h1;
            cyc(1);
            chk("own_line", pbr_n, exp);
            if (i == 0)
                chk("single_master", 6'(mst), 6'h01);
            want = 1'h0;
        end
    endtask : t_straps
    // peer and host contention, then host takeover of an owned bus
    task automatic t_arb;
        do_reset(3'h2);
        chk("grant_idle", 6'(goe_n), 6'h01);
        preq = 6'h01;
        hreq = 1'h1;
        want = 1'h1;
        cyc(4);
        chk("both_pending", 6'(mst), 6'h00);
        preq = 6'h00;
        cyc(3);
        chk("host_first", 6'(mst), 6'h00);
        hreq = 1'h0;
        cyc(2);
        chk("master", 6'(mst), 6'h01);
        chk("driving", 6'(boe_n), 6'h00);
        hreq = 1'h1;
        cyc(1);
        chk("bus_float", 6'(boe_n), 6'h01);
        chk("grant_late", 6'(gnt_w), 6'h01);
        cyc(1);
        chk("grant", 6'(gnt_w), 6'h00);
        chk("grant_reg", 6'(gnt_n), 6'h00);
        chk("grant_drv", 6'(goe_n), 6'h00);
        cyc(6);
        chk("grant_hold", 6'(gnt_w), 6'h00);
        chk("grant_seen", 6'(seen), 6'h01);
        hreq = 1'h0;
        cyc(1);
        chk("grant_off", 6'(gnt_w), 6'h01);
    endtask : t_arb
    // suspend while owning the bus, with a core access pending
    task automatic t_suspend;
        cyc(2);
        sus_n = 1'h0;
        acc = 1'h1;
        #1 chk("stall", 6'(stall), 6'h01);
        cyc(1);
        chk("sus_float", 6'(boe_n), 6'h01);
        cyc(3);
        chk("sus_hold", 6'(stall), 6'h01);
        sus_n = 1'h1;
        #1 chk("stall_until_driven", 6'(stall), 6'h01);
        cyc(1);
        chk("redrive", 6'(boe_n), 6'h00);
        chk("unstall", 6'(stall), 6'h00);
        acc = 1'h0;
        want = 1'h0;
    endtask : t_suspend
    // all select, request, drive-mode and wait combinations of the ready pin
    task automatic t_ready;
        for (int i = 0; i < 16; i++) begin
            {hcs, hreq, sel, wait_r} = 4'(i);
            #1 chk("ready", 6'(rdy), 6'(!wait_r));
            chk("ready_oe", 6'(roe_n), 6'(!(hcs && hreq && (sel || wait_r))));
            cyc(1);
        end
    endtask : t_ready
    task automatic conclude;
        $display("tests %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : conclude
    // main sequence
    initial begin
        t_straps();
        t_arb();
        t_suspend();
        t_ready();
        conclude();
    end
    // watchdog, about twelve times the expected run
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        conclude();
    end
endmodule : test_ebo_bus_owner
